// *** isr_defs.vh ***
// constants for the status and event register bank
`ifndef ISR_DEFS_VH
`define ISR_DEFS_VH

// register selects on the command port
`define ISR_SEL_QPOW_COND   4'h0
`define ISR_SEL_QPOW_EVT    4'h1
`define ISR_SEL_QCAL_COND   4'h2
`define ISR_SEL_QCAL_EVT    4'h3
`define ISR_SEL_STD_EVT     4'h4
`define ISR_SEL_STD_ENA     4'h5
`define ISR_SEL_OPER_COND   4'h6
`define ISR_SEL_OPER_EVT    4'h7
`define ISR_SEL_OPER_ENA    4'h8

// questionable power status bits
`define ISR_QPOW_CORRUPT    1
`define ISR_QPOW_ZERO_STALE 5
`define ISR_QPOW_MASK       16'h0022

// questionable calibration status bits
`define ISR_QCAL_ZERO_FAIL  1
`define ISR_QCAL_MASK       16'h0002

// standard event status bits
`define ISR_STD_OPC         0
`define ISR_STD_QUERY_ERR   2
`define ISR_STD_DEV_ERR     3
`define ISR_STD_EXEC_ERR    4
`define ISR_STD_CMD_ERR     5
`define ISR_STD_USER_REQ    6
`define ISR_STD_POWER_ON    7
`define ISR_STD_MASK        16'h00FD
`define ISR_STD_RESET       16'h0080
`define ISR_STD_ENA_MASK    16'h00FF

// operation status bits
`define ISR_OPER_CALIB      0
`define ISR_OPER_MEAS       4
`define ISR_OPER_TRIG       5
`define ISR_OPER_MASK       16'h0031

// error number ranges, signed 16 bit
`define ISR_DEV_ERR_LO      16'hFE71
`define ISR_DEV_ERR_HI      16'hFED4
`define ISR_EXEC_ERR_LO     16'hFED4
`define ISR_EXEC_ERR_HI     16'hFF38
`define ISR_CMD_ERR_LO      16'hFF38
`define ISR_CMD_ERR_HI      16'hFF9C

`endif

// *** isr_evt_bits.v ***
// condition and event pair with read-to-clear event latch
`timescale 1ns/1ps
`default_nettype none

module isr_evt_bits #(
  parameter [15:0] MASK = 16'hFFFF,
  parameter [15:0] RST  = 16'h0000
) (
  input  wire        mclk,     // system clock
  input  wire        nrst,     // async reset, active low
  input  wire [15:0] cond,     // live condition levels
  input  wire [15:0] setPulse, // direct event set pulses
  input  wire        rdClr,    // event part read this cycle
  output reg  [15:0] condQ,    // registered condition part
  output reg  [15:0] evtQ      // latched event part
);

  wire [15:0] rise;
  wire [15:0] setBits;

  // a rising condition counts as an occurrence
  assign rise    = cond & ~condQ;
  assign setBits = (rise | setPulse) & MASK;

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      condQ <= 16'h0000;
      evtQ  <= RST & MASK;
    end
    else
    begin
      condQ <= cond & MASK;
      // set wins over the read clear so no event is lost
      if (rdClr)
        evtQ <= setBits;
      else
        evtQ <= evtQ | setBits;
    end
  end

endmodule

`default_nettype wire

// *** isr_status_regs.v ***
// status and event register bank with command-port access
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.vh"

// Summary of operation
// RL1: set questionable power bit 1 while measurement data is corrupt.
// RL2: set questionable power bit 5 when zero correction is stale.
// RL3: questionable calibration has condition and event parts for zero validity.
// RL4: set questionable calibration bit 1 when zeroing failed.
// RL5: standard event register is event type, returned on its query.
// RL6: standard event enable register is writable and readable by controller.
// RL7: after operation-complete command, set bit 0 once prior commands finish.
// RL8: set bit 2 on read without query or commands before response collected.
// RL9: device error sets bit 3 and queues -300..-399 or positive number; not queued if a command or execution error comes in the same cycle.
// RL10: execution error sets bit 4 and queues number in -200..-300; nothing is queued for it if a command error comes in the same cycle.
// RL11: command error sets bit 5 and queues number in -100..-200.
// RL12: set bit 6 when control switches to manual operation.
// RL13: set bit 7 at power on.
// RL14: operation condition shows current activity, event records since last read.
// RL15: operation bit 0 set while calibrating.
// RL16: operation bit 4 set while measuring.
// RL17: operation bit 5 set while waiting for trigger.
// RL18: status byte bit 7 set when an enabled operation event is set.
// RL19: unused bits read zero and ignore writes; bit 1 of the standard event enable register still takes writes and reads back.
// RL20: event bits stay latched until their register is read, read clears.
module isr_status_regs (
  input  wire        mclk,         // system clock, 250 MHz
  input  wire        nrst,         // async reset, active low
  // command port from the text parser
  input  wire        acsValid,     // access request strobe
  input  wire        acsWrite,     // 1 write, 0 read
  input  wire [3:0]  acsSel,       // register select
  input  wire [15:0] acsWrData,    // write data
  output reg  [15:0] rdData_q,     // read data
  output reg         rdValid_q,    // read data valid pulse
  // status sources from the measurement logic
  input  wire        dataCorrupt,  // measurement data corrupt
  input  wire        zeroStale,    // zero correction no longer valid
  input  wire        zeroFail,     // last zeroing did not succeed
  input  wire        calibrating,  // calibration in progress
  input  wire        measuring,    // measurement in progress
  input  wire        waitTrig,     // waiting for trigger event
  // standard event sources
  input  wire        opcCmd,       // operation-complete command received
  input  wire        allDone,      // all earlier commands executed
  input  wire        readNoQuery,  // read attempted with no query sent
  input  wire        cmdOverrun,   // new command before response collected
  input  wire        devErr,       // device-dependent error pulse
  input  wire        execErr,      // execution error pulse
  input  wire        cmdErr,       // command error pulse
  input  wire [15:0] errNum,       // error number offered with the pulse
  input  wire        userReq,      // switched over to manual control
  // error queue feed and summaries
  output reg         errPush_q,    // push pulse toward the error queue
  output reg  [15:0] errCode_q,    // error number to queue
  output reg         operSum_q,    // status byte bit 7
  output reg         stdSum_q      // enabled standard event summary
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // signed range test, lo inclusive, hi exclusive
  function inRange;
    input [15:0] num;
    input [15:0] lo;
    input [15:0] hi;
    begin
      inRange = ($signed(num) >= $signed(lo)) && ($signed(num) < $signed(hi));
    end
  endfunction

  function [15:0] selRead;
    input [3:0] sel;
    input [3:0] want;
    input [15:0] val;
    begin
      selRead = (sel == want) ? val : 16'h0000;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  wire        rdStb;
  wire        wrStb;
  wire        rdQpowEvt;
  wire        rdQcalEvt;
  wire        rdStdEvt;
  wire        rdOperEvt;

  assign rdStb     = acsValid & ~acsWrite;
  assign wrStb     = acsValid & acsWrite;
  assign rdQpowEvt = rdStb & (acsSel == `ISR_SEL_QPOW_EVT);
  assign rdQcalEvt = rdStb & (acsSel == `ISR_SEL_QCAL_EVT);
  assign rdStdEvt  = rdStb & (acsSel == `ISR_SEL_STD_EVT);
  assign rdOperEvt = rdStb & (acsSel == `ISR_SEL_OPER_EVT);

  ////////////////////////////////////////////////////////////////////////////
  // questionable power and calibration

  wire [15:0] qpowCondIn;
  wire [15:0] qcalCondIn;
  wire [15:0] qpowCond;
  wire [15:0] qpowEvt;
  wire [15:0] qcalCond;
  wire [15:0] qcalEvt;

  assign qpowCondIn = ({15'h0000, dataCorrupt} << `ISR_QPOW_CORRUPT)  // [RL1]
                    | ({15'h0000, zeroStale} << `ISR_QPOW_ZERO_STALE); // [RL2]
  assign qcalCondIn = {15'h0000, zeroFail} << `ISR_QCAL_ZERO_FAIL;      // [RL4]

  isr_evt_bits #(
    .MASK (`ISR_QPOW_MASK),
    .RST  (16'h0000)
  ) uQpow (
    .mclk     (mclk),
    .nrst     (nrst),
    .cond     (qpowCondIn),
    .setPulse (16'h0000),
    .rdClr    (rdQpowEvt),
    .condQ    (qpowCond),
    .evtQ     (qpowEvt)
  );

  // both parts follow the zero validity  [RL3]
  isr_evt_bits #(
    .MASK (`ISR_QCAL_MASK),
    .RST  (16'h0000)
  ) uQcal (
    .mclk     (mclk),
    .nrst     (nrst),
    .cond     (qcalCondIn),
    .setPulse (16'h0000),
    .rdClr    (rdQcalEvt),
    .condQ    (qcalCond),
    .evtQ     (qcalEvt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // operation-complete tracking

  reg opcPend_q;
  reg opcPend_d;
  reg opcFire;

  // the command may be completed in the very cycle it arrives
  always @*
  begin
    opcFire   = 1'b0;
    opcPend_d = opcPend_q;
    if ((opcPend_q | opcCmd) & allDone)
    begin
      opcFire   = 1'b1;                                    // [RL7]
      opcPend_d = 1'b0;
    end
    else if (opcCmd)
      opcPend_d = 1'b1;
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      opcPend_q <= 1'b0;
    else
      opcPend_q <= opcPend_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // standard event status

  wire [15:0] stdSet;
  wire [15:0] stdEvt;

  assign stdSet = ({15'h0000, opcFire} << `ISR_STD_OPC)                        // [RL7]
                | ({15'h0000, readNoQuery | cmdOverrun} << `ISR_STD_QUERY_ERR) // [RL8]
                | ({15'h0000, devErr} << `ISR_STD_DEV_ERR)                     // [RL9]
                | ({15'h0000, execErr} << `ISR_STD_EXEC_ERR)                   // [RL10]
                | ({15'h0000, cmdErr} << `ISR_STD_CMD_ERR)                     // [RL11]
                | ({15'h0000, userReq} << `ISR_STD_USER_REQ);                  // [RL12]

  // reset value carries the power-on bit  [RL13]
  isr_evt_bits #(
    .MASK (`ISR_STD_MASK),
    .RST  (`ISR_STD_RESET)
  ) uStd (
    .mclk     (mclk),
    .nrst     (nrst),
    .cond     (16'h0000),
    .setPulse (stdSet),
    .rdClr    (rdStdEvt),                                 // [RL5]
    .condQ    (),
    .evtQ     (stdEvt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // operation status

  wire [15:0] operCondIn;
  wire [15:0] operCond;
  wire [15:0] operEvt;

  assign operCondIn = ({15'h0000, calibrating} << `ISR_OPER_CALIB) // [RL15]
                    | ({15'h0000, measuring} << `ISR_OPER_MEAS)    // [RL16]
                    | ({15'h0000, waitTrig} << `ISR_OPER_TRIG);    // [RL17]

  // condition tracks activity, event holds starts since last read  [RL14]
  isr_evt_bits #(
    .MASK (`ISR_OPER_MASK),
    .RST  (16'h0000)
  ) uOper (
    .mclk     (mclk),
    .nrst     (nrst),
    .cond     (operCondIn),
    .setPulse (16'h0000),
    .rdClr    (rdOperEvt),                                // [RL20]
    .condQ    (operCond),
    .evtQ     (operEvt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // enable registers

  reg [15:0] stdEna_q;
  reg [15:0] operEna_q;

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      stdEna_q  <= 16'h0000;
      operEna_q <= 16'h0000;
    end
    else if (wrStb)
    begin
      if (acsSel == `ISR_SEL_STD_ENA)
        stdEna_q <= acsWrData & `ISR_STD_ENA_MASK;        // [RL6] [RL19]
      if (acsSel == `ISR_SEL_OPER_ENA)
        operEna_q <= acsWrData & `ISR_OPER_MASK;          // [RL19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // summaries

  // registered so the status byte sees a clean level
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      operSum_q <= 1'b0;
      stdSum_q  <= 1'b0;
    end
    else
    begin
      operSum_q <= |(operEvt & operEna_q);                 // [RL18]
      stdSum_q  <= |(stdEvt & stdEna_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error queue feed

  reg        errPush_d;
  reg [15:0] errCode_d;

  // one entry per cycle: command error outranks execution, execution
  // outranks device; a number outside the class range is replaced by
  // the exclusive top of that class range: -100, -200 or -300
  always @*
  begin
    errPush_d = 1'b0;
    errCode_d = 16'h0000;
    if (cmdErr)
    begin
      errPush_d = 1'b1;
      if (inRange(errNum, `ISR_CMD_ERR_LO, `ISR_CMD_ERR_HI))       // [RL11]
        errCode_d = errNum;
      else
        errCode_d = `ISR_CMD_ERR_HI;
    end
    else if (execErr)
    begin
      errPush_d = 1'b1;
      if (inRange(errNum, `ISR_EXEC_ERR_LO, `ISR_EXEC_ERR_HI))     // [RL10]
        errCode_d = errNum;
      else
        errCode_d = `ISR_EXEC_ERR_HI;
    end
    else if (devErr)
    begin
      errPush_d = 1'b1;
      if (inRange(errNum, `ISR_DEV_ERR_LO, `ISR_DEV_ERR_HI)
          || ($signed(errNum) > $signed(16'h0000)))                 // [RL9]
        errCode_d = errNum;
      else
        errCode_d = `ISR_DEV_ERR_HI;
    end
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      errPush_q <= 1'b0;
      errCode_q <= 16'h0000;
    end
    else
    begin
      errPush_q <= errPush_d;
      errCode_q <= errCode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  reg [15:0] rdMux;

  // unmapped selects read zero; masked parts keep unused bits at zero
  always @*
  begin
    rdMux = selRead(acsSel, `ISR_SEL_QPOW_COND, qpowCond)
          | selRead(acsSel, `ISR_SEL_QPOW_EVT,  qpowEvt)
          | selRead(acsSel, `ISR_SEL_QCAL_COND, qcalCond)
          | selRead(acsSel, `ISR_SEL_QCAL_EVT,  qcalEvt)
          | selRead(acsSel, `ISR_SEL_STD_EVT,   stdEvt)           // [RL5]
          | selRead(acsSel, `ISR_SEL_STD_ENA,   stdEna_q)         // [RL6]
          | selRead(acsSel, `ISR_SEL_OPER_COND, operCond)
          | selRead(acsSel, `ISR_SEL_OPER_EVT,  operEvt)
          | selRead(acsSel, `ISR_SEL_OPER_ENA,  operEna_q);       // [RL19]
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdData_q  <= 16'h0000;
      rdValid_q <= 1'b0;
    end
    else
    begin
      rdValid_q <= rdStb;
      if (rdStb)
        rdData_q <= rdMux;
    end
  end

endmodule

`default_nettype wire

// *** isr_status_regs_chk.sv ***
// assertion checker for the status and event register bank
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.vh"
module isr_status_regs_chk (
  input wire        mclk,        // clock
  input wire        nrst,        // reset, active low
  input wire        acsValid,    // access strobe
  input wire        acsWrite,    // write qualifier
  input wire [3:0]  acsSel,      // register select
  input wire [15:0] rdData_q,    // read data
  input wire        rdValid_q,   // read answer
  input wire        dataCorrupt, // corrupt data level
  input wire        zeroStale,   // stale zero level
  input wire        calibrating, // calibration level
  input wire        measuring,   // measurement level
  input wire        waitTrig,    // trigger wait level
  input wire        devErr,      // device error pulse
  input wire        execErr,     // execution error pulse
  input wire        cmdErr,      // command error pulse
  input wire [15:0] errNum,      // offered error number
  input wire        errPush_q,   // queue push
  input wire [15:0] errCode_q    // queued number
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire rdReq  = acsValid && !acsWrite;
  wire anyErr = cmdErr || execErr || devErr;
  wire cmdIn  = $signed(errNum) >= -200 && $signed(errNum) < -100;
  ////////////////////////////////////////////////////////////////////////////////
  AST_READ_ANSWER: assert property (rdReq |=> rdValid_q)
    else $error("read strobe not answered");
  AST_NO_STRAY_ANSWER: assert property (!rdReq |=> !rdValid_q)
    else $error("read answer without read");
  AST_ERR_PUSH: assert property (anyErr |=> errPush_q)
    else $error("error not pushed");
  AST_ERR_QUIET: assert property (!anyErr |=> !errPush_q)
    else $error("push without error");
  AST_CMD_CODE: assert property (cmdErr && cmdIn |=> errCode_q == $past(errNum))
    else $error("command error number altered");
  AST_CMD_DEFAULT: assert property (cmdErr && !cmdIn |=> errCode_q == 16'hFF9C)
    else $error("command error number out of range");
  // condition parts lag their inputs by one register stage
  AST_QPOW_COND: assert property (rdReq && acsSel == `ISR_SEL_QPOW_COND && $past(nrst) |=>
    rdData_q == {10'h000, $past(zeroStale, 2), 3'h0, $past(dataCorrupt, 2), 1'h0})
    else $error("power condition read wrong");
  AST_OPER_COND: assert property (rdReq && acsSel == `ISR_SEL_OPER_COND && $past(nrst) |=>
    rdData_q == {10'h000, $past(waitTrig, 2), $past(measuring, 2), 3'h0,
    $past(calibrating, 2)})
    else $error("operation condition read wrong");
  AST_STD_UNUSED: assert property (rdReq && acsSel == `ISR_SEL_STD_EVT |=>
    rdData_q[15:8] == 8'h00 && !rdData_q[1])
    else $error("unused event bit set");
endmodule
bind isr_status_regs isr_status_regs_chk chk_u (.mclk(mclk), .nrst(nrst),
  .acsValid(acsValid), .acsWrite(acsWrite), .acsSel(acsSel), .rdData_q(rdData_q),
  .rdValid_q(rdValid_q), .dataCorrupt(dataCorrupt), .zeroStale(zeroStale),
  .calibrating(calibrating), .measuring(measuring), .waitTrig(waitTrig), .devErr(devErr),
  .execErr(execErr), .cmdErr(cmdErr), .errNum(errNum), .errPush_q(errPush_q),
  .errCode_q(errCode_q));
`default_nettype wire

// *** isr_ctrl_model.sv ***
// remote controller model issuing register commands and queries
`timescale 1ns/1ps
`default_nettype none
module isr_ctrl_model (
  input  wire logic        mclk,      // clock
  input  wire logic [15:0] rdData_q,  // query answer data
  input  wire logic        rdValid_q, // query answer strobe
  output var  logic        acsValid,  // access strobe
  output var  logic        acsWrite,  // 1 command, 0 query
  output var  logic [3:0]  acsSel,    // register select
  output var  logic [15:0] acsWrData  // command data
);
  initial
  begin
    acsValid  = 1'b0;
    acsWrite  = 1'b0;
    acsSel    = 4'h0;
    acsWrData = 16'h0000;
  end
  // one access per call; a write or a query of whichever register is selected
  task automatic acc(input logic wr, input logic [3:0] sel, input logic [15:0] d,
                     output logic [15:0] q, output logic ok);
    @(posedge mclk);
    acsValid  <= 1'b1;
    acsWrite  <= wr;
    acsSel    <= sel;
    acsWrData <= d;
    @(posedge mclk);
    acsValid  <= 1'b0;
    // released data shows no stale value
    acsWrData <= ~d;
    #1;
    q  = rdData_q;
    ok = rdValid_q === !wr;
  endtask
endmodule
`default_nettype wire

// *** isr_status_regs_tb.sv ***
// self-checking testbench for the status and event register bank
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.vh"
module isr_status_regs_tb;
  logic        mclk;
  logic        nrst;
  logic [5:0]  lv;
  logic [5:0]  ev;
  logic        opcCmd;
  logic        allDone;
  logic [15:0] errNum;
  wire         acsValid, acsWrite, rdValid_q, errPush_q, operSum_q, stdSum_q;
  wire  [3:0]  acsSel;
  wire  [15:0] acsWrData, rdData_q, errCode_q;
  int          err_total = 0;
  int          cmp_count = 0;
  logic [15:0] rv;
  logic        ok;
  isr_status_regs dut_u (.mclk(mclk), .nrst(nrst), .acsValid(acsValid),
    .acsWrite(acsWrite), .acsSel(acsSel), .acsWrData(acsWrData), .rdData_q(rdData_q),
    .rdValid_q(rdValid_q), .dataCorrupt(lv[0]), .zeroStale(lv[1]), .zeroFail(lv[2]),
    .calibrating(lv[3]), .measuring(lv[4]), .waitTrig(lv[5]), .opcCmd(opcCmd),
    .allDone(allDone), .readNoQuery(ev[0]), .cmdOverrun(ev[1]), .devErr(ev[2]),
    .execErr(ev[3]), .cmdErr(ev[4]), .errNum(errNum), .userReq(ev[5]),
    .errPush_q(errPush_q), .errCode_q(errCode_q), .operSum_q(operSum_q),
    .stdSum_q(stdSum_q));
  isr_ctrl_model ctrl_u (.mclk(mclk), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
    .acsValid(acsValid), .acsWrite(acsWrite), .acsSel(acsSel), .acsWrData(acsWrData));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [3:0] sel, input logic [15:0] exp, input string nm);
    ctrl_u.acc(1'b0, sel, 16'h0000, rv, ok);
    chk({nm, " valid"}, 16'h0001, {15'h0000, ok});
    chk(nm, exp, rv);
  endtask
  task automatic wr(input logic [3:0] sel, input logic [15:0] d);
    ctrl_u.acc(1'b1, sel, d, rv, ok);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power_on;
    rd(`ISR_SEL_STD_EVT, 16'h0080, "power on");
    rd(`ISR_SEL_STD_EVT, 16'h0000, "std cleared");
    rd(4'hF, 16'h0000, "unmapped");
    $display("test power_on done");
  endtask
  task automatic t_questionable;
    @(posedge mclk);
    lv <= 6'h07;
    tick(2);
    rd(`ISR_SEL_QPOW_COND, 16'h0022, "qpow cond");
    rd(`ISR_SEL_QPOW_EVT, 16'h0022, "qpow evt");
    rd(`ISR_SEL_QPOW_EVT, 16'h0000, "qpow evt clr");
    rd(`ISR_SEL_QCAL_COND, 16'h0002, "qcal cond");
    rd(`ISR_SEL_QCAL_EVT, 16'h0002, "qcal evt");
    wr(`ISR_SEL_QPOW_COND, 16'hFFFF);
    rd(`ISR_SEL_QPOW_COND, 16'h0022, "qpow ro");
    @(posedge mclk);
    lv <= 6'h00;
    tick(2);
    rd(`ISR_SEL_QCAL_COND, 16'h0000, "qcal low");
    $display("test questionable done");
  endtask
  task automatic t_std_events;
    // last three: out-of-range command number, in-range device number, all errors at once
    logic [5:0]  pat [9] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h10, 6'h04, 6'h1C};
    logic [15:0] num [9] = '{16'h0000, 16'h0000, 16'h0005, 16'hFFCE, 16'hFF6A, 16'h0000,
                             16'h0005, 16'hFEA2, 16'hFF6A};
    logic [15:0] code [9] = '{16'h0000, 16'h0000, 16'h0005, 16'hFF38, 16'hFF6A, 16'h0000,
                              16'hFF9C, 16'hFEA2, 16'hFF6A};
    logic [15:0] stdv [9] = '{16'h0004, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0040,
                              16'h0020, 16'h0008, 16'h0038};
    for (int i = 0; i < 9; i++)
    begin
      @(posedge mclk);
      ev     <= pat[i];
      errNum <= num[i];
      @(posedge mclk);
      ev <= 6'h00;
      #1;
      chk("err push", {15'h0000, |pat[i][4:2]}, {15'h0000, errPush_q});
      if (|pat[i][4:2])
        chk("err code", code[i], errCode_q);
      rd(`ISR_SEL_STD_EVT, stdv[i], "std bit");
    end
    $display("test std_events done");
  endtask
  task automatic t_enable;
    wr(`ISR_SEL_STD_ENA, 16'hFFFF);
    rd(`ISR_SEL_STD_ENA, 16'h00FF, "std ena");
    wr(`ISR_SEL_STD_ENA, 16'h0020);
    @(posedge mclk);
    ev     <= 6'h10;
    errNum <= 16'hFF6A;
    @(posedge mclk);
    ev <= 6'h00;
    tick(2);
    #1;
    chk("std sum", 16'h0001, {15'h0000, stdSum_q});
    rd(`ISR_SEL_STD_EVT, 16'h0020, "cmd err");
    tick(2);
    #1;
    chk("std sum clr", 16'h0000, {15'h0000, stdSum_q});
    $display("test enable done");
  endtask
  task automatic t_opc;
    @(posedge mclk);
    opcCmd <= 1'b1;
    @(posedge mclk);
    opcCmd <= 1'b0;
    tick(3);
    rd(`ISR_SEL_STD_EVT, 16'h0000, "opc early");
    @(posedge mclk);
    allDone <= 1'b1;
    tick(2);
    rd(`ISR_SEL_STD_EVT, 16'h0001, "opc set");
    // with everything already done the command completes in its own cycle
    @(posedge mclk);
    opcCmd <= 1'b1;
    @(posedge mclk);
    opcCmd <= 1'b0;
    rd(`ISR_SEL_STD_EVT, 16'h0001, "opc same cycle");
    $display("test opc done");
  endtask
  task automatic t_oper;
    wr(`ISR_SEL_OPER_ENA, 16'hFFFF);
    rd(`ISR_SEL_OPER_ENA, 16'h0031, "oper ena");
    wr(`ISR_SEL_OPER_ENA, 16'h0010);
    @(posedge mclk);
    lv <= 6'h38;
    tick(3);
    #1;
    chk("oper sum", 16'h0001, {15'h0000, operSum_q});
    rd(`ISR_SEL_OPER_EVT, 16'h0031, "oper evt");
    tick(2);
    #1;
    chk("oper sum clr", 16'h0000, {15'h0000, operSum_q});
    rd(`ISR_SEL_OPER_COND, 16'h0031, "oper cond");
    $display("test oper done");
  endtask
  // mid-run reset: enables drop, power-on returns, active conditions rise again
  task automatic t_reset;
    @(posedge mclk);
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    rd(`ISR_SEL_STD_ENA, 16'h0000, "std ena reset");
    rd(`ISR_SEL_STD_EVT, 16'h0080, "power on again");
    rd(`ISR_SEL_OPER_EVT, 16'h0031, "oper evt reset");
    $display("test reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #100000;
    err_total++;
    report_and_stop;
  end
  initial
  begin
    lv      = 6'h00;
    ev      = 6'h00;
    opcCmd  = 1'b0;
    allDone = 1'b0;
    errNum  = 16'h0000;
    nrst    = 1'b0;
    tick(2);
    nrst <= 1'b1;
    t_power_on;
    t_questionable;
    t_std_events;
    t_enable;
    t_opc;
    t_oper;
    t_reset;
    report_and_stop;
  end
endmodule
`default_nettype wire
